// >>> src/boie_exec.sv
`timescale 1ns/100ps
module boie_exec
  import boie_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Fetch path
  input  wire logic              instrValid,
  input  wire logic [WORD_W-1:0] instrWord,
  // Register file read port
  output logic      [ADDR_W-1:0] rdAddr,
  input  wire logic [DATA_W-1:0] rdData,
  // Register file write port
  output boie_wr_t               wrReq,
  // Flow control and phase
  output logic      [1:0]        qPhase,
  output logic                   skipNext,
  output logic                   nopCycle,
  output logic                   cycleDone,
  output logic                   busy
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_FLUSH
  } boie_state_t;

  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  boie_state_t       state;
  boie_state_t       next_state;
  logic [1:0]        q;
  boie_dec_t         cur;
  logic [DATA_W-1:0] latched;
  logic              tested;
  boie_dec_t         decNow;
  logic [DATA_W-1:0] aluOut;
  logic              aluBit;

  // Decode of the incoming word happens combinationally in Q1
  boie_decode uDec (
    .word (instrWord),
    .dec  (decNow)
  );

  // Bit modify and bit test share one lane selector
  boie_bit_alu uAlu (
    .dataIn   (latched),
    .bitSel   (cur.bitSel),
    .op       (cur.op),
    .dataOut  (aluOut),
    .bitValue (aluBit)
  );

  wire logic startOp  = instrValid && (decNow.op != BOIE_OP_NONE);
  wire logic isWrite  = (cur.op == BOIE_OP_CLEAR) || (cur.op == BOIE_OP_SET);
  wire logic isTest   = (cur.op == BOIE_OP_TEST);
  wire logic lastQ    = (q == Q4);
  wire logic takeSkip = isTest && !tested;
  // Prefetched word taken at every cycle end, except the one a taken skip discards
  wire logic takeWord = lastQ && !((state == ST_EXEC) && takeSkip);

  // Phase sequencing: Q1 decode, Q2 read, Q3 process, Q4 write or no-op
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (startOp && lastQ) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (lastQ && takeSkip) begin
          next_state = ST_FLUSH;
        end else if (lastQ) begin
          next_state = startOp ? ST_EXEC : ST_IDLE;
        end
      end
      ST_FLUSH: begin
        if (lastQ) begin
          next_state = startOp ? ST_EXEC : ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Free-running quarter-cycle counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= Q1;
    end else begin
      q <= q + 2'h1;
    end
  end

  // State and captured instruction; capture only at a cycle boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cur   <= '{op: BOIE_OP_NONE, bitSel: '0, fileAddr: ADDR_RST};
    end else begin
      state <= next_state;
      if (takeWord) begin
        cur <= decNow;
      end
    end
  end

  // Q2 read, Q3 modify or test
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched <= DATA_RST;
      tested  <= 1'b1;
    end else if (state == ST_EXEC) begin
      if (q == Q2) begin
        latched <= rdData;
      end
      if (q == Q3) begin
        tested  <= aluBit;
      end
    end
  end

  // Next values of the registered outputs; write only for clear and set in Q4
  wire logic next_wrEn = (state == ST_EXEC) && isWrite && (q == Q3);
  wire logic next_skip = (next_state == ST_FLUSH);
  wire logic next_done = (q == Q3) && (state != ST_IDLE);
  wire logic next_busy = (next_state != ST_IDLE);

  // Register file side; data follows the modifier so it is ready at Q4
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdAddr <= ADDR_RST;
      wrReq  <= '{en: 1'b0, addr: ADDR_RST, data: DATA_RST};
    end else begin
      rdAddr <= cur.fileAddr;
      wrReq  <= '{en: next_wrEn, addr: cur.fileAddr, data: aluOut};
    end
  end

  // Phase mirror, flow control and status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qPhase    <= Q1;
      skipNext  <= 1'b0;
      nopCycle  <= 1'b0;
      cycleDone <= 1'b0;
      busy      <= 1'b0;
    end else begin
      qPhase    <= q + 2'h1;
      skipNext  <= next_skip;
      nopCycle  <= next_skip;
      cycleDone <= next_done;
      busy      <= next_busy;
    end
  end

endmodule : boie_exec

// >>> src/boie_pkg.sv
// Behaviour
// - Operands are a 3-bit bit number 0..7 and a 7-bit file address 0..127.
// - Word 01 00 bbb fffffff decodes as the bit clear operation.
// - Word 01 01 bbb fffffff decodes as the bit set operation.
// - Word 01 10 bbb fffffff decodes as test bit, skip if clear.
// - Bit clear forces the chosen bit to zero, other bits untouched.
// - Bit set forces the chosen bit to one, other bits untouched.
// - Clear and set take one cycle: decode, read, modify, write back.
// - Test decodes, reads, tests in Q3, does nothing in Q4, never writes.
// - Tested bit one: next instruction runs normally, test costs one cycle.
// - Tested bit zero: prefetched next instruction is discarded, replaced by no-op.
// - A taken skip makes the test two cycles, second cycle all no-op.
package boie_pkg;

  localparam int WORD_W = 14;
  localparam int ADDR_W = 7;
  localparam int BIT_W  = 3;
  localparam int DATA_W = 8;

  // Field positions within the program word
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 10;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int ADR_HI = 6;
  localparam int ADR_LO = 0;

  // Encodings
  localparam logic [1:0] CLS_BITOP  = 2'h1;
  localparam logic [1:0] OPC_CLEAR  = 2'h0;
  localparam logic [1:0] OPC_SET    = 2'h1;
  localparam logic [1:0] OPC_TEST   = 2'h2;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

  typedef enum logic [1:0] {
    BOIE_OP_NONE,
    BOIE_OP_CLEAR,
    BOIE_OP_SET,
    BOIE_OP_TEST
  } boie_op_t;

  // Decoded instruction
  typedef struct packed {
    boie_op_t          op;
    logic [BIT_W-1:0]  bitSel;
    logic [ADDR_W-1:0] fileAddr;
  } boie_dec_t;

  // Register file write request
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } boie_wr_t;

endpackage : boie_pkg

// >>> src/boie_decode.sv
`timescale 1ns/100ps
module boie_decode
  import boie_pkg::*;
(
  // Program word in
  input  wire logic [WORD_W-1:0] word,
  // Decoded fields out
  output boie_dec_t              dec
);

  wire logic [1:0] cls = word[CLS_HI:CLS_LO];
  wire logic [1:0] opc = word[OPC_HI:OPC_LO];

  // Only class 01 is ours; opcode 11 belongs to another group
  assign dec.op       = (cls != CLS_BITOP) ? BOIE_OP_NONE :
                        (opc == OPC_CLEAR) ? BOIE_OP_CLEAR :
                        (opc == OPC_SET)   ? BOIE_OP_SET :
                        (opc == OPC_TEST)  ? BOIE_OP_TEST :
                        BOIE_OP_NONE;
  assign dec.bitSel   = word[BIT_HI:BIT_LO];
  assign dec.fileAddr = word[ADR_HI:ADR_LO];

endmodule : boie_decode

// >>> src/boie_bit_alu.sv
`timescale 1ns/100ps
module boie_bit_alu
  import boie_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] dataIn,
  input  wire logic [BIT_W-1:0]  bitSel,
  input  boie_op_t               op,
  // Results
  output logic      [DATA_W-1:0] dataOut,
  output logic                   bitValue
);

  wire logic [DATA_W-1:0] mask = {{(DATA_W-1){1'b0}}, 1'b1} << bitSel;

  // Only the selected lane changes; no carry or zero logic exists here
  assign dataOut  = (op == BOIE_OP_CLEAR) ? (dataIn & ~mask) :
                    (op == BOIE_OP_SET)   ? (dataIn | mask) :
                    dataIn;
  assign bitValue = dataIn[bitSel];

endmodule : boie_bit_alu

// >>> tb/boie_exec_properties.sv
`timescale 1ns/100ps
module boie_exec_properties
  import boie_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // Watched ports
  input wire logic [DATA_W-1:0] rdData,
  input wire logic [ADDR_W-1:0] rdAddr,
  input boie_wr_t               wrReq,
  input wire logic [1:0]        qPhase,
  input wire logic              skipNext,
  input wire logic              nopCycle,
  input wire logic              cycleDone,
  input wire logic              busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write back, one clock, in Q4
  AST_WR_Q4: assert property (wrReq.en |-> qPhase == 2'h3 ##1 !wrReq.en) else $error("bad write");
  AST_WR_ADDR: assert property (wrReq.en |-> wrReq.addr == rdAddr) else $error("bad addr");
  // At most one bit may differ from the read data
  AST_WR_ONE_BIT: assert property (wrReq.en |-> $countones(wrReq.data ^ rdData) <= 1) else $error("bits");
  AST_SKIP_NO_WR: assert property (skipNext |-> !wrReq.en) else $error("skip wrote");
  AST_SKIP_LEN: assert property ($rose(skipNext) |-> skipNext[*4] ##1 !skipNext) else $error("skip len");
  AST_NOP_SKIP: assert property (nopCycle == skipNext) else $error("nop");
  AST_PHASE_WRAP: assert property (qPhase == 2'h3 |=> qPhase == 2'h0) else $error("phase");
  AST_DONE_Q4: assert property (cycleDone |-> qPhase == 2'h3) else $error("done");
  AST_SKIP_BUSY: assert property (skipNext |-> busy) else $error("skip idle");
  AST_DONE_BUSY: assert property (cycleDone |-> busy) else $error("done idle");
  // Main scenarios
  cover property (wrReq.en);
  cover property ($rose(skipNext));
  cover property (wrReq.en && wrReq.data[7]);
  cover property (wrReq.en ##4 wrReq.en);
endmodule : boie_exec_properties

// >>> tb/bit_oriented_instruction_exec_tb.sv
`timescale 1ns/100ps
module bit_oriented_instruction_exec_tb;
  import boie_pkg::*;
  `define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  typedef struct packed {
    logic [13:0] w, nxt;
    logic [6:0]  a;
    logic [7:0]  init, exp;
    logic        sk;
  } boie_row_t;
  logic        clk = 0, sys_rst = 1, instrValid = 0, sk;
  logic [13:0] instrWord = '0;
  logic [7:0]  mem [128];
  logic [7:0]  rdData;
  logic [6:0]  rdAddr;
  boie_wr_t    wrReq;
  logic [1:0]  qPhase;
  logic        skipNext, nopCycle, cycleDone, busy;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  // Word, next word, address, before, after, skip
  boie_row_t rows [8] = '{
    '{14'h13ff, 14'h0000, 7'h7f, 8'hc7, 8'h47, 1'h0}, '{14'h1780, 14'h0000, 7'h00, 8'h0a, 8'h8a, 1'h0},
    '{14'h1883, 14'h1783, 7'h03, 8'h02, 8'h82, 1'h0}, '{14'h1883, 14'h1783, 7'h03, 8'hfd, 8'hfd, 1'h1},
    '{14'h1d04, 14'h0000, 7'h04, 8'h00, 8'h00, 1'h0}, '{14'h13ff, 14'h147f, 7'h7f, 8'hc6, 8'h47, 1'h0},
    '{14'h1bff, 14'h0000, 7'h7f, 8'h7f, 8'h7f, 1'h1}, '{14'h0405, 14'h0000, 7'h05, 8'h55, 8'h55, 1'h0}};
  boie_exec dut (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid), .instrWord(instrWord),
    .rdAddr(rdAddr), .rdData(rdData), .wrReq(wrReq), .qPhase(qPhase), .skipNext(skipNext),
    .nopCycle(nopCycle), .cycleDone(cycleDone), .busy(busy));
  // Register file stand-in, read is combinational
  assign rdData = mem[rdAddr];
  always @(posedge clk) if (wrReq.en) mem[wrReq.addr] <= wrReq.data;
  always #12.5 clk = ~clk;
  // Hang guard, rows need under 40 clocks each
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic step(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (skipNext === 1'b1) sk = 1;
    end
  endtask : step
  // Word held a full cycle up to its Q4 capture, follower held one more cycle
  task automatic run(boie_row_t r);
    mem[r.a] = r.init;
    sk = 0;
    do step(1); while (qPhase !== 2'h0);
    instrWord = r.w;
    instrValid = 1;
    do step(1); while (qPhase !== 2'h3);
    step(1);
    instrWord = r.nxt;
    step(4);
    instrWord = '0;
    instrValid = 0;
    step(12);
  endtask : run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    step(4);
    sys_rst = 0;
    foreach (rows[i]) begin
      run(rows[i]);
      `CHK("mem", rows[i].exp, mem[rows[i].a])
      `CHK("skip", rows[i].sk, sk)
      $display("row %0d done", i);
    end
    // Reset in Q2 of a set operation; its write must not land
    mem[1] = 8'h10;
    instrWord = 14'h1401;
    instrValid = 1;
    do step(1); while (qPhase !== 2'h3);
    step(2);
    `CHK("busyExec", 1'b1, busy)
    sys_rst = 1;
    step(1);
    `CHK("busy", 1'b0, busy)
    `CHK("wrEn", 1'b0, wrReq.en)
    `CHK("skip", 1'b0, skipNext)
    `CHK("memHeld", 8'h10, mem[1])
    sys_rst = 0;
    // Word still offered, so it runs once the phases restart
    step(12);
    `CHK("memAfter", 8'h11, mem[1])
    instrValid = 0;
    $display("reset test done");
    stop_test();
  end
endmodule : bit_oriented_instruction_exec_tb
bind boie_exec boie_exec_properties chk (.clk(clk), .sys_rst(sys_rst), .rdData(rdData),
  .rdAddr(rdAddr), .wrReq(wrReq), .qPhase(qPhase), .skipNext(skipNext), .nopCycle(nopCycle),
  .cycleDone(cycleDone), .busy(busy));
